// *** src/cmc_pkg.sv ***
// Constants, types and command decode for the cache miss controller
package cmc_pkg;
  localparam int CMD_W   = 5;
  localparam int MS_W    = 4;
  localparam int TAG_W   = 8;
  localparam int PAR_N   = 5;
  localparam int PAR_DW  = 8;
  localparam int STG_N   = 3;
  localparam int STG_W   = CMD_W + 1;
  localparam int CHAIN_W = MS_W + STG_N * STG_W;
  localparam int BUS_W   = 32;

  // Register map, byte addresses
  localparam logic [3:0] REG_STATUS  = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam int STAT_MS_LSB   = 0;
  localparam int STAT_ERROR    = 4;
  localparam int STAT_BROKEN   = 5;
  localparam int STAT_WR_ERROR = 6;
  localparam int STAT_MASTER   = 7;
  localparam int STAT_KIND_LSB = 8;
  localparam int CTRL_MAINT    = 0;
  localparam int CTRL_ERR_CLR  = 1;
  localparam logic CTRL_MAINT_RST = 1'b0;

  localparam logic [1:0] MEM_CMD_BIT_NONE  = 2'h0;
  localparam logic [1:0] MEM_CMD_BIT_READ  = 2'h1;
  localparam logic [1:0] MEM_CMD_BIT_WRITE = 2'h2;
  localparam logic [3:0] WSEL_ONE   = 4'h1;

  typedef enum logic [MS_W-1:0] {
    MS_IDLE = 4'h0, MS_WRBACK = 4'h1, MS_MEMREQ = 4'h2, MS_WAIT0 = 4'h3,
    MS_WAIT1 = 4'h4, MS_WAIT2 = 4'h5, MS_WAIT3 = 4'h6, MS_WAIT4 = 4'h7,
    MS_WAIT5 = 4'h8, MS_LOAD_MDR = 4'h9, MS_LOAD_ECC = 4'hA, MS_UPD0 = 4'hB,
    MS_UPD1 = 4'hC, MS_UPD2 = 4'hD, MS_UNUSED = 4'hE, MS_MAINT = 4'hF
  } cmc_miss_state_t;

  typedef enum logic [4:0] {
    K_OP_READ, K_READ_DATA, K_IO_WRITE, K_IO_READ, K_TEST_ERR, K_READ_BASE,
    K_READ_LIMIT, K_INVALID, K_ERROR_CMD, K_WRITE_PC, K_READ_PC, K_READ_ERR_ADDR,
    K_READ_ERR_REP, K_RESERVED, K_READ_LOCK, K_WRITE_BACK, K_WRITE_BASE,
    K_WRITE_LIMIT, K_WRITE_DATA, K_OP_READ_UNC
  } cmc_kind_t;

  typedef enum logic [1:0] {
    SN_IO_RD_PUB = 2'h0, SN_CACHE_RD_PUB = 2'h1, SN_IO_WRITE = 2'h2, SN_RMW_PRIV = 2'h3
  } cmc_snoop_t;

  typedef struct packed {
    logic       valid;
    cmc_snoop_t cmd;
  } cmc_snoop_cmd_t;

  typedef struct packed {
    logic             par;
    logic [CMD_W-1:0] code;
  } cmc_stage_t;

  typedef struct packed {
    logic       mem_request;
    logic [1:0] mem_cmd;
    logic       update_cache;
  } cmc_crit_t;

  typedef struct packed {
    logic [PAR_DW-1:0] data;
    logic              par;
  } cmc_par_grp_t;

  function automatic cmc_kind_t cmc_decode(input logic [CMD_W-1:0] code);
    unique case (code)
      5'h00: return K_OP_READ;
      5'h01: return K_READ_DATA;
      5'h02: return K_IO_WRITE;
      5'h03: return K_IO_READ;
      5'h04: return K_TEST_ERR;
      5'h05: return K_READ_BASE;
      5'h07: return K_READ_LIMIT;
      5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h1A, 5'h1E: return K_INVALID;
      5'h0C, 5'h0D, 5'h0E, 5'h0F: return K_ERROR_CMD;
      5'h10: return K_WRITE_PC;
      5'h11: return K_READ_PC;
      5'h12: return K_READ_ERR_ADDR;
      5'h13: return K_READ_ERR_REP;
      5'h14, 5'h15, 5'h17, 5'h1C: return K_RESERVED;
      5'h16: return K_READ_LOCK;
      5'h18: return K_WRITE_BACK;
      5'h19: return K_WRITE_BASE;
      5'h1B: return K_WRITE_LIMIT;
      5'h1D: return K_WRITE_DATA;
      5'h1F: return K_OP_READ_UNC;
    endcase
  endfunction : cmc_decode

  function automatic logic cmc_is_write(input cmc_kind_t k);
    return k inside {K_IO_WRITE, K_WRITE_PC, K_WRITE_BACK, K_WRITE_BASE, K_WRITE_LIMIT,
                     K_WRITE_DATA};
  endfunction : cmc_is_write

  function automatic logic cmc_is_read(input cmc_kind_t k);
    return k inside {K_OP_READ, K_READ_DATA, K_IO_READ, K_READ_BASE, K_READ_LIMIT,
                     K_READ_PC, K_READ_ERR_ADDR, K_READ_ERR_REP, K_READ_LOCK,
                     K_OP_READ_UNC};
  endfunction : cmc_is_read

  function automatic logic cmc_needs_mem(input cmc_kind_t k);
    return k inside {K_OP_READ, K_READ_DATA, K_READ_LOCK, K_OP_READ_UNC};
  endfunction : cmc_needs_mem
endpackage : cmc_pkg

// *** src/cmc_par_chk.sv ***
// Registered odd-parity checker for one incoming parity group
`timescale 1ns/100ps
module cmc_par_chk
  import cmc_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // Checked group
  input  wire cmc_par_grp_t grp,
  output logic              err_q
);
  always_ff @(posedge clock) begin
    if (reset) begin
      err_q <= 1'b0;
    end else if (clk_en) begin
      err_q <= ~^grp;
    end
  end
endmodule : cmc_par_chk

// *** src/cmc_miss_ctrl.sv ***
// Cache miss controller: miss sequencer, command pipeline, checking, register slave
//
// How it works
// - Miss sequencing uses a 4-bit state, fifteen codes used, one unused.
// - State 0 idle, state 1 writes victim back, state 2 requests bus.
// - States 3 to 8 wait for memory data; state 9 loads data/ECC register.
// - State 10 starts ECC check, 11 to 13 wait to update, 15 maintenance.
// - Codes 00-05 and 07 decode to the basic read, io and test commands.
// - Codes 06, 08-0B, 1A, 1E invalid; 0C-0F error; 14,15,17,1C reserved.
// - Codes 10-13 write PC, read PC, error address, error report.
// - Codes 16,18,19,1B,1D,1F lock read, write back, bases, limits, data, raw read.
// - Jumper high makes this instance master driving critical signals; low only checks.
// - A slave flags any mismatch against the master's signals as broken.
// - Master drives memory command bit 1, slave drives bit 0.
// - Parity is checked on address, command, snoop address, snoop command, length.
// - The force-error input reports a hardware error.
// - After memory grant the next waiting memory request may be issued.
// - Tag select high sources result bus from T3 tag, else T2 tag.
// - Two address LSBs make the four-line word select.
// - Two status outputs show a write or a read command is held.
// - Load strobe loads the PC register; setup strobe makes the array write ECC.
// - Fatal error output, and a separate write error output.
// - Shift chain holds miss state, three stage command codes and their parities.
// - Limit error is over-limit AND check request delayed one clock.
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module cmc_miss_ctrl
  import cmc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // Maintenance shift chain
  input  wire logic                  scan_in,
  input  wire logic                  scan_shift,
  input  wire logic                  scan_clear,
  output logic                       scan_out,
  // Processor command pipeline
  input  wire logic                  cmd_valid,
  input  wire logic [CMD_W-1:0]      cmd_pipe_in,
  input  wire logic                  cmd_par_in,
  output logic                       proc_pipe_hold,
  output logic                       stage2_hold,
  output cmc_kind_t                  cmd_kind,
  output logic                       holds_write_status,
  output logic                       holds_read_status,
  // Cache and memory handshake
  input  wire logic                  cache_miss,
  input  wire logic                  replace_needed,
  input  wire logic                  mem_grant,
  input  wire logic                  mem_data_valid,
  input  wire logic                  cache_update_ok,
  output logic                       mem_request,
  output logic                       mem_cmd_bit,
  output logic                       update_cache,
  output logic                       miss_idle,
  // Master/slave duplicate compare
  input  wire logic                  master_jumper,
  input  wire cmc_crit_t             crit_i,
  output cmc_crit_t                  crit_o,
  output logic                       crit_oe,
  // Data path steering
  input  wire logic                  tag_reg_select,
  input  wire logic [TAG_W-1:0]      tag_t2,
  input  wire logic [TAG_W-1:0]      tag_t3,
  input  wire logic [1:0]            addr_lsb,
  output logic [TAG_W-1:0]           result_bus,
  output logic [3:0]                 word_select_n,
  output logic                       load_pc_n,
  output logic                       write_ecc_setup_n,
  // Snoop pipeline
  input  wire logic                  bus_phase,
  input  wire cmc_snoop_cmd_t        snoop_cmd_in,
  output cmc_snoop_cmd_t             snoop_cmd_out,
  // Checking and errors
  input  wire cmc_par_grp_t [PAR_N-1:0] par_grp,
  input  wire logic                  force_hw_error,
  input  wire logic                  over_limit,
  input  wire logic                  check_limit,
  output logic                       limit_error_n,
  output logic                       error,
  output logic                       write_error,
  output logic                       hw_broken,
  // Avalon-MM slave
  input  wire logic [3:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [BUS_W-1:0]      avs_writedata,
  output logic [BUS_W-1:0]           avs_readdata,
  output logic                       avs_waitrequest
);
  cmc_miss_state_t         ms_q, ms_d;
  cmc_stage_t [STG_N-1:0]  stg_q;
  logic [STG_N-1:0]        stg_vld_q;
  logic [CHAIN_W-1:0]      chain_sh;
  logic [PAR_N-1:0]        grp_err;
  logic [STG_N-1:0]        stg_wr, stg_rd;
  logic                    jmp_s1_q, master_q;
  logic                    served_q, maint_q, chk_limit_q;
  logic                    run, advance, miss_start, t3_par_err, err_ev, broken_ev, wr_err_ev;
  logic                    acc, err_clr;
  cmc_kind_t               kind;
  cmc_crit_t               crit_d;
  cmc_snoop_cmd_t          snoop1_q;
  logic [BUS_W-1:0]        status_w;

  assign run        = clk_en & ~scan_shift & ~scan_clear;
  assign kind       = cmc_decode(stg_q[2].code);
  assign t3_par_err = stg_vld_q[2] & ~^stg_q[2];
  assign miss_start = stg_vld_q[2] & ~served_q & cache_miss & cmc_needs_mem(kind);
  assign advance    = ~proc_pipe_hold & ~miss_start;
  assign chain_sh   = {ms_q[MS_W-2:0], stg_q[2], stg_q[1], stg_q[0], scan_in};
  assign scan_out   = ms_q[MS_W-1];

  // Miss sequencer next state
  always_comb begin
    ms_d = ms_q;
    unique case (ms_q)
      MS_IDLE: begin
        if (maint_q) ms_d = MS_MAINT;
        else if (miss_start) ms_d = replace_needed ? MS_WRBACK : MS_MEMREQ;
      end
      MS_WRBACK:   if (mem_grant) ms_d = MS_MEMREQ;
      MS_MEMREQ:   if (mem_grant) ms_d = MS_WAIT0;
      MS_WAIT0, MS_WAIT1, MS_WAIT2, MS_WAIT3, MS_WAIT4:
        ms_d = cmc_miss_state_t'(ms_q + 4'h1);
      MS_WAIT5:    if (mem_data_valid) ms_d = MS_LOAD_MDR;
      MS_LOAD_MDR: ms_d = MS_LOAD_ECC;
      MS_LOAD_ECC: ms_d = MS_UPD0;
      MS_UPD0, MS_UPD1: ms_d = cmc_miss_state_t'(ms_q + 4'h1);
      MS_UPD2:     if (cache_update_ok) ms_d = MS_IDLE;
      MS_UNUSED:   ms_d = MS_IDLE;
      MS_MAINT:    if (!maint_q) ms_d = MS_IDLE;
    endcase
  end

  // Miss state register, part of the shift chain
  always_ff @(posedge clock) begin
    if (reset) begin
      ms_q <= MS_IDLE;
    end else if (clk_en) begin
      if (scan_clear) ms_q <= MS_IDLE;
      else if (scan_shift) ms_q <= cmc_miss_state_t'(chain_sh[CHAIN_W-1 -: MS_W]);
      else ms_q <= ms_d;
    end
  end

  // Command pipeline T1 -> T2 -> T3
  always_ff @(posedge clock) begin
    if (reset) begin
      stg_q     <= '0;
      stg_vld_q <= '0;
    end else if (clk_en) begin
      if (scan_clear) begin
        stg_q     <= '0;
        stg_vld_q <= '0;
      end else if (scan_shift) begin
        stg_q <= chain_sh[STG_N*STG_W-1:0];
      end else if (advance) begin
        stg_q     <= {stg_q[1:0], cmd_par_in, cmd_pipe_in};
        stg_vld_q <= {stg_vld_q[1:0], cmd_valid};
      end
    end
  end

  // Served flag keeps a finished miss from restarting on the same T3 command
  always_ff @(posedge clock) begin
    if (reset) begin
      served_q       <= 1'b0;
      proc_pipe_hold <= 1'b0;
      stage2_hold    <= 1'b0;
      cmd_kind       <= K_OP_READ;
    end else if (run) begin
      if (ms_q == MS_UPD2 && cache_update_ok) served_q <= 1'b1;
      else if (advance) served_q <= 1'b0;
      proc_pipe_hold <= ms_d != MS_IDLE;
      stage2_hold    <= (ms_d != MS_IDLE) & stg_vld_q[1];
      cmd_kind       <= kind;
    end
  end

  // Per-stage read/write classification
  for (genvar i = 0; i < STG_N; i++) begin : g_stage
    assign stg_wr[i] = stg_vld_q[i] & cmc_is_write(cmc_decode(stg_q[i].code));
    assign stg_rd[i] = stg_vld_q[i] & cmc_is_read(cmc_decode(stg_q[i].code));
  end

  // Critical control group and memory command
  always_comb begin
    crit_d.mem_request  = ms_d inside {MS_WRBACK, MS_MEMREQ};
    crit_d.mem_cmd      = (ms_d == MS_WRBACK) ? MEM_CMD_BIT_WRITE :
                          (ms_d == MS_MEMREQ) ? MEM_CMD_BIT_READ : MEM_CMD_BIT_NONE;
    crit_d.update_cache = ms_d inside {MS_UPD0, MS_UPD1, MS_UPD2};
  end

  // Jumper synchroniser and master/slave drive
  always_ff @(posedge clock) begin
    if (reset) begin
      jmp_s1_q <= 1'b0;
      master_q <= 1'b0;
      crit_oe  <= 1'b0;
      crit_o   <= '0;
    end else if (clk_en) begin
      jmp_s1_q <= master_jumper;
      master_q <= jmp_s1_q;
      crit_oe  <= master_q;
      crit_o   <= crit_d;
    end
  end

  // Own outputs toward memory, cache and data section
  always_ff @(posedge clock) begin
    if (reset) begin
      mem_request        <= 1'b0;
      mem_cmd_bit        <= 1'b0;
      update_cache       <= 1'b0;
      miss_idle          <= 1'b1;
      result_bus         <= '0;
      word_select_n      <= '1;
      load_pc_n          <= 1'b1;
      write_ecc_setup_n  <= 1'b1;
      holds_write_status <= 1'b0;
      holds_read_status  <= 1'b0;
    end else if (clk_en) begin
      mem_request        <= crit_d.mem_request;
      mem_cmd_bit        <= master_q ? crit_d.mem_cmd[1] : crit_d.mem_cmd[0];
      update_cache       <= crit_d.update_cache;
      miss_idle          <= ms_d == MS_IDLE;
      result_bus         <= tag_reg_select ? tag_t3 : tag_t2;
      word_select_n      <= ~(WSEL_ONE << addr_lsb);
      load_pc_n          <= ~(stg_vld_q[2] & (kind == K_WRITE_PC) & advance);
      write_ecc_setup_n  <= ~(ms_d == MS_LOAD_ECC);
      holds_write_status <= |stg_wr;
      holds_read_status  <= |stg_rd;
    end
  end

  // Snoop command pipeline, loaded in bus phase
  always_ff @(posedge clock) begin
    if (reset) begin
      snoop1_q      <= '0;
      snoop_cmd_out <= '0;
    end else if (clk_en && bus_phase) begin
      snoop1_q      <= snoop_cmd_in;
      snoop_cmd_out <= snoop1_q;
    end
  end

  // Incoming parity groups
  for (genvar g = 0; g < PAR_N; g++) begin : g_par
    cmc_par_chk u_chk (
      .clock  (clock),
      .reset  (reset),
      .clk_en (clk_en),
      .grp    (par_grp[g]),
      .err_q  (grp_err[g])
    );
  end

  assign broken_ev = ~master_q & (crit_o != crit_i);
  assign err_ev    = force_hw_error | (ms_q == MS_UNUSED) | (|grp_err) | t3_par_err |
                     broken_ev | (stg_vld_q[2] & (kind inside {K_INVALID, K_ERROR_CMD}));
  assign wr_err_ev = stg_wr[2] & (t3_par_err | (|grp_err));

  // Sticky errors; a new event wins over a software clear
  always_ff @(posedge clock) begin
    if (reset) begin
      error       <= 1'b0;
      write_error <= 1'b0;
      hw_broken   <= 1'b0;
    end else if (clk_en) begin
      if (err_ev) error <= 1'b1;
      else if (err_clr) error <= 1'b0;
      if (wr_err_ev) write_error <= 1'b1;
      else if (err_clr) write_error <= 1'b0;
      if (broken_ev) hw_broken <= 1'b1;
      else if (err_clr) hw_broken <= 1'b0;
    end
  end

  // Limit error qualification
  always_ff @(posedge clock) begin
    if (reset) begin
      chk_limit_q   <= 1'b0;
      limit_error_n <= 1'b1;
    end else if (clk_en) begin
      chk_limit_q   <= check_limit;
      limit_error_n <= ~(over_limit & chk_limit_q);
    end
  end

  // Register slave
  assign acc     = (avs_read | avs_write) & ~avs_waitrequest;
  assign err_clr = acc & avs_write & (avs_address == REG_CONTROL) & avs_writedata[CTRL_ERR_CLR];

  always_comb begin
    status_w = '0;
    status_w[STAT_MS_LSB +: MS_W] = ms_q;
    status_w[STAT_ERROR]          = error;
    status_w[STAT_BROKEN]         = hw_broken;
    status_w[STAT_WR_ERROR]       = write_error;
    status_w[STAT_MASTER]         = master_q;
    status_w[STAT_KIND_LSB +: 5]  = cmd_kind;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if (clk_en) begin
      if (acc) begin
        avs_waitrequest <= 1'b1;
      end else if (avs_read | avs_write) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= '0;
        if (avs_read && avs_address == REG_STATUS) avs_readdata <= status_w;
        if (avs_read && avs_address == REG_CONTROL) avs_readdata[CTRL_MAINT] <= maint_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      maint_q <= CTRL_MAINT_RST;
    end else if (clk_en && acc && avs_write && avs_address == REG_CONTROL) begin
      maint_q <= avs_writedata[CTRL_MAINT];
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_unused_state: assert property (run && ms_q == MS_UNUSED |=> ms_q == MS_IDLE && error)
    else $error("unused miss state not recovered");
  a_grant_wait: assert property (run && ms_q == MS_MEMREQ && !mem_grant
                                 |=> ms_q == MS_MEMREQ && mem_request)
    else $error("memory request dropped before grant");
  a_data_wait: assert property (run && ms_q == MS_WAIT0 ##1 run[*5]
                                |-> ms_q == MS_WAIT5)
    else $error("data wait states not stepped");
  a_pipe_advance: assert property (run && advance |=> stg_q[2] == $past(stg_q[1]))
    else $error("pipeline did not advance");
  a_tag_select: assert property (clk_en |=>
                                 result_bus == ($past(tag_reg_select) ? $past(tag_t3)
                                                                      : $past(tag_t2)))
    else $error("result bus from wrong tag register");
  a_word_select: assert property (clk_en ##1 clk_en |-> $countones(~word_select_n) == 1)
    else $error("word select not one-hot");
  a_force_error: assert property (clk_en && force_hw_error |=> error)
    else $error("forced error not reported");
  a_slave_check: assert property (clk_en && !master_q && crit_o != crit_i |=> hw_broken)
    else $error("slave mismatch not flagged");
  a_limit_delay: assert property (clk_en ##1 clk_en |=>
                                  limit_error_n == !($past(over_limit, 1) && $past(check_limit, 2)))
    else $error("limit error not qualified by delayed check");
  a_master_drive: assert property (clk_en ##1 clk_en |-> crit_oe == $past(master_q))
    else $error("output enable does not follow jumper");

  c_miss_full: cover property (ms_q == MS_UPD2 ##1 ms_q == MS_IDLE);
  c_writeback: cover property (ms_q == MS_WRBACK ##1 ms_q == MS_MEMREQ);
  c_broken:    cover property ($rose(hw_broken));
  c_bus_read:  cover property (avs_read && !avs_waitrequest);
endmodule : cmc_miss_ctrl

// *** bench/cmc_mem_model.sv ***
// Memory bus controller model answering miss traffic
`timescale 1ns/100ps
module cmc_mem_model (
  // Clock, reset and answer latency
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [7:0] lat,
  // Miss handshake
  input  wire logic       mem_request,
  input  wire logic       miss_idle,
  input  wire logic       update_cache,
  output logic            mem_grant,
  output logic            mem_data_valid,
  output logic            cache_update_ok
);
  logic [7:0] cnt_q;
  logic       hit;

  // Answers repeat every lat+1 cycles until the sequencer moves on
  assign hit             = (cnt_q >= lat) && !miss_idle;
  assign mem_grant       = hit && mem_request;
  assign mem_data_valid  = hit && !mem_request && !update_cache;
  assign cache_update_ok = hit && update_cache;

  always_ff @(posedge clock) begin
    if (reset || miss_idle || hit) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end
endmodule : cmc_mem_model

// *** bench/cmc_miss_ctrl_tb.sv ***
// Self-checking bench for the cache miss controller
`timescale 1ns/100ps
module cmc_miss_ctrl_tb;
  import cmc_pkg::*;
  logic clock, reset = 1'b1, master_jumper = 1'b1, bad = 1'b0, pc_seen = 1'b0;
  logic cmd_valid = 1'b0, cmd_par_in = 1'b1, cache_miss = 1'b0, replace_needed = 1'b0;
  logic [4:0] cmd_pipe_in = 5'h00;
  logic tag_reg_select = 1'b0, bus_phase = 1'b0, force_hw_error = 1'b0;
  logic scan_in = 1'b0, scan_shift = 1'b0, scan_out;
  logic over_limit = 1'b0, check_limit = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0] tag_t2 = 8'h3C, tag_t3 = 8'hA5, lat = 8'h00;
  logic [1:0] addr_lsb = 2'h0;
  logic [3:0] avs_address = 4'h0, word_select_n;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  cmc_snoop_cmd_t snoop_cmd_in = 3'h0, snoop_cmd_out;
  cmc_par_grp_t [PAR_N-1:0] par_grp = {PAR_N{9'h001}};
  cmc_crit_t crit_i, crit_o;
  cmc_kind_t cmd_kind;
  logic proc_pipe_hold, holds_write_status, holds_read_status, mem_request, mem_cmd_bit;
  logic update_cache, miss_idle, crit_oe, load_pc_n, write_ecc_setup_n, limit_error_n;
  logic error, write_error, hw_broken, avs_waitrequest, mem_grant, mem_data_valid;
  logic [7:0] result_bus;
  logic cache_update_ok;
  int num_errors = 0, check_count = 0;
  cmc_kind_t kt [32] = '{K_OP_READ, K_READ_DATA, K_IO_WRITE, K_IO_READ, K_TEST_ERR,
    K_READ_BASE, K_INVALID, K_READ_LIMIT, K_INVALID, K_INVALID, K_INVALID, K_INVALID,
    K_ERROR_CMD, K_ERROR_CMD, K_ERROR_CMD, K_ERROR_CMD, K_WRITE_PC, K_READ_PC,
    K_READ_ERR_ADDR, K_READ_ERR_REP, K_RESERVED, K_RESERVED, K_READ_LOCK, K_RESERVED,
    K_WRITE_BACK, K_WRITE_BASE, K_INVALID, K_WRITE_LIMIT, K_RESERVED, K_WRITE_DATA,
    K_INVALID, K_OP_READ_UNC};

  // Healthy partner copy of the critical signals, bad flips one bit while crit_oe is low
  assign crit_i = crit_oe ? crit_o : cmc_crit_t'(crit_o ^ {3'h0, bad});

  cmc_miss_ctrl cmc_miss_ctrl_i (.clock, .reset, .clk_en(1'b1), .scan_in,
    .scan_shift, .scan_clear(1'b0), .scan_out, .cmd_valid, .cmd_pipe_in,
    .cmd_par_in, .proc_pipe_hold, .stage2_hold(), .cmd_kind, .holds_write_status,
    .holds_read_status, .cache_miss, .replace_needed, .mem_grant, .mem_data_valid,
    .cache_update_ok, .mem_request, .mem_cmd_bit, .update_cache, .miss_idle,
    .master_jumper, .crit_i, .crit_o, .crit_oe, .tag_reg_select, .tag_t2, .tag_t3,
    .addr_lsb, .result_bus, .word_select_n, .load_pc_n, .write_ecc_setup_n, .bus_phase,
    .snoop_cmd_in, .snoop_cmd_out, .par_grp, .force_hw_error, .over_limit, .check_limit,
    .limit_error_n, .error, .write_error, .hw_broken, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);

  cmc_mem_model cmc_mem_model_i (.clock, .reset, .lat, .mem_request, .miss_idle,
    .update_cache, .mem_grant, .mem_data_valid, .cache_update_ok);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) if (load_pc_n === 1'b0) pc_seen <= 1'b1;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk(32'(n), 32'h2);
  endtask : bus

  task rst;
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : rst

  task clr;
    bus(1'b1, REG_CONTROL, 32'h2);
    @(posedge clock);
    chk(32'({error, write_error}), 32'h0);
  endtask : clr

  task t_decode;
    for (int c = 0; c < 32; c++) begin
      cmd_pipe_in <= 5'(c);
      cmd_par_in <= ~^5'(c);
      cmd_valid <= 1'b1;
      repeat (6) @(posedge clock);
      chk(32'(cmd_kind), 32'(kt[c]));
      chk(32'(holds_write_status), 32'(5'(c) inside {5'h02, 5'h10, 5'h18, 5'h19, 5'h1B,
        5'h1D}));
      chk(32'(holds_read_status), 32'(5'(c) inside {5'h00, 5'h01, 5'h03, 5'h05, 5'h07,
        5'h11, 5'h12, 5'h13, 5'h16, 5'h1F}));
      cmd_valid <= 1'b0;
      repeat (5) @(posedge clock);
      chk(32'(error), 32'(kt[c] inside {K_INVALID, K_ERROR_CMD}));
      clr;
    end
    chk(32'(pc_seen), 32'h1);
    $display("decode test done");
  endtask : t_decode

  task t_miss(input logic [7:0] l);
    logic w, r, e, u;
    {w, r, e, u} = 4'h0;
    lat <= l;
    cmd_pipe_in <= 5'h00;
    cmd_par_in <= 1'b1;
    cmd_valid <= 1'b1;
    cache_miss <= 1'b1;
    replace_needed <= 1'b1;
    for (int n = 0; n < 400 && !(u && miss_idle === 1'b1); n++) begin
      @(posedge clock);
      if (mem_request === 1'b1) begin
        cache_miss <= 1'b0;
        cmd_valid <= 1'b0;
        if (mem_cmd_bit === 1'b1) w = 1'b1;
        if (mem_cmd_bit === 1'b0 && w) r = 1'b1;
      end
      if (write_ecc_setup_n === 1'b0) e = 1'b1;
      if (update_cache === 1'b1 && proc_pipe_hold === 1'b1) u = 1'b1;
    end
    replace_needed <= 1'b0;
    chk(32'({w, r}), 32'h3);
    chk(32'({e, u}), 32'h3);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[3:0], 32'h0);
    $display("miss test done");
  endtask : t_miss

  task t_err;
    force_hw_error <= 1'b1;
    @(posedge clock);
    force_hw_error <= 1'b0;
    repeat (3) @(posedge clock);
    chk(32'(error), 32'h1);
    clr;
    for (int g = 0; g < PAR_N; g++) begin
      par_grp[g].par <= 1'b0;
      repeat (2) @(posedge clock);
      par_grp[g].par <= 1'b1;
      repeat (3) @(posedge clock);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(32'(q[STAT_ERROR]), 32'h1);
      clr;
    end
    cmd_pipe_in <= 5'h02;
    cmd_par_in <= 1'b0;
    cmd_valid <= 1'b1;
    par_grp[1].par <= 1'b0;
    repeat (6) @(posedge clock);
    cmd_valid <= 1'b0;
    par_grp[1].par <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(write_error), 32'h1);
    clr;
    $display("error test done");
  endtask : t_err

  task t_misc;
    int n;
    for (int i = 0; i < 4; i++) begin
      tag_reg_select <= i[0];
      addr_lsb <= 2'(i);
      snoop_cmd_in <= '{valid: 1'b1, cmd: cmc_snoop_t'(2'(i))};
      bus_phase <= 1'b1;
      repeat (4) @(posedge clock);
      chk(32'(result_bus), i[0] ? 32'hA5 : 32'h3C);
      chk(32'(word_select_n), 32'(4'(~(WSEL_ONE << i))));
      chk(32'(snoop_cmd_out), 32'({1'b1, 2'(i)}));
    end
    for (int k = 0; k < 2; k++) begin
      n = 0;
      for (int s = 0; s < 8; s++) begin
        check_limit <= (s == 0);
        over_limit <= (s == k);
        @(posedge clock);
        if (limit_error_n === 1'b0) n++;
      end
      chk(32'(n), 32'(k));
    end
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(32'({q[STAT_MASTER], crit_oe}), 32'h3);
    bus(1'b1, REG_CONTROL, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(32'(q[3:0]), 32'hF);
    bus(1'b1, REG_CONTROL, 32'h0);
    $display("steering test done");
  endtask : t_misc

  task t_slave;
    master_jumper <= 1'b0;
    rst;
    chk(32'({crit_oe, hw_broken}), 32'h0);
    bad <= 1'b1;
    repeat (4) @(posedge clock);
    chk(32'(hw_broken), 32'h1);
    $display("slave test done");
  endtask : t_slave

  task t_scan;
    scan_shift <= 1'b1;
    scan_in <= 1'b1;
    repeat (22) @(posedge clock);
    chk(32'(scan_out), 32'h0);
    @(posedge clock);
    chk(32'(scan_out), 32'h1);
    scan_in <= 1'b0;
    @(posedge clock);
    scan_in <= 1'b1;
    repeat (18) @(posedge clock);
    scan_shift <= 1'b0;
    repeat (2) @(posedge clock);
    chk(32'({error, miss_idle}), 32'h3);
    $display("scan test done");
  endtask : t_scan

  task test_done;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (60000) @(posedge clock);
    num_errors++;
    test_done;
  end

  initial begin
    rst;
    chk(32'({miss_idle, avs_waitrequest, error, write_ecc_setup_n}), 32'hD);
    t_decode;
    t_miss(8'h00);
    t_miss(8'h03);
    t_err;
    t_misc;
    rst;
    t_scan;
    t_slave;
    test_done;
  end
endmodule : cmc_miss_ctrl_tb
